//--- hw/i2c_data_buffer_flags.sv
// Module: data buffer split, automatic transfers and continuous-transfer flags, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module i2c_data_buffer_flags
	import i2c_buf_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic        SCL_IN,
	input  wire logic        SDA_IN,
	output logic             SDA_OUT,
	output logic             SDA_OE_N,
	output logic             IRQ
);
	typedef struct packed {
		logic                 aw_held;
		logic [7:0]           aw_addr;
		logic                 w_held;
		logic [31:0]          w_data;
		logic [3:0]           w_strb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 arready;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic [4:0]           control;
		logic [6:0]           second_address;
		logic [7:0]           frame_shift_register;
		logic [7:0]           receive_holding_buffer;
		logic [7:0]           transmit_holding_buffer;
		logic                 transmit_buffer_empty;
		logic                 receive_buffer_full;
		logic                 common_irq_flag;
		logic                 continuous_transfer_irq_flag;
		logic                 cont_read_one;
		logic                 second_address_match_flag;
		logic                 match_read_one;
		logic                 first_frame;
		logic [IRQ_W-1:0]     irq_status;
		logic [IRQ_W-1:0]     irq_mask;
		logic                 irq;
		logic                 sda_out;
	} buf_state_type;
	buf_state_type state;
	buf_state_type next_state;
	link_event_if  ev ();
	logic          wr_fire;
	logic          rd_fire;
	logic          enabled;
	logic          slave_mode;
	logic          transmit_mode;
	logic          set_empty;
	logic          set_full;
	logic          set_cont;
	logic          set_match;
	logic [IRQ_W-1:0] irq_events;
	logic [7:0]    wbyte;

	link_frame_tracker u_tracker (
		.CLK      (CLK),
		.SRST     (SRST),
		.scl_in   (SCL_IN),
		.sda_in   (SDA_IN),
		.lsb_first(state.control[CTL_LSB_FIRST_BIT]),
		.ev       (ev)
	);

	assign ev.load_byte = state.frame_shift_register;

	always_comb begin
		enabled = state.control[CTL_ENABLE_BIT];
		slave_mode = state.control[CTL_SLAVE_BIT];
		transmit_mode = state.control[CTL_TRANSMIT_BIT];
		wr_fire = state.aw_held && state.w_held && !state.bvalid;
		rd_fire = state.arready && S_AXI_ARVALID;
		wbyte = state.w_data[7:0];
		set_empty = 1'b0;
		set_full = 1'b0;
		set_match = 1'b0;

		next_state = state;
		// Write address and data are caught independently, in either order
		if (!state.aw_held && S_AXI_AWVALID) begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = S_AXI_AWADDR;
		end
		if (!state.w_held && S_AXI_WVALID) begin
			next_state.w_held = 1'b1;
			next_state.w_data = S_AXI_WDATA;
			next_state.w_strb = S_AXI_WSTRB;
		end
		if (state.bvalid && S_AXI_BREADY) begin
			next_state.bvalid = 1'b0;
		end
		if (state.rvalid && S_AXI_RREADY) begin
			next_state.rvalid = 1'b0;
			next_state.arready = 1'b1;
		end else if (!state.rvalid) begin
			next_state.arready = 1'b1;
		end
		if (rd_fire) begin
			next_state.arready = 1'b0;
		end

		// Link side: frame end moves data between the three parts of the register
		if (ev.frame_done) begin
			if (transmit_mode) begin
				if (!state.transmit_buffer_empty) begin
					next_state.frame_shift_register = state.transmit_holding_buffer;
					set_empty = 1'b1;
				end
			end else begin
				next_state.frame_shift_register = ev.frame_byte;
				if (!state.receive_buffer_full) begin
					next_state.receive_holding_buffer = ev.frame_byte;
					set_full = 1'b1;
				end
			end
			if (slave_mode && !transmit_mode && state.first_frame
			    && ev.frame_byte[7:1] == state.second_address) begin
				set_match = 1'b1;
			end
			next_state.first_frame = 1'b0;
		end
		if (ev.start_seen) begin
			next_state.first_frame = 1'b1;
		end
		set_cont = (set_empty || set_full)
		           && (!slave_mode || state.second_address_match_flag || set_match);

		// Software writes
		if (wr_fire) begin
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = RESP_OKAY;
			case (state.aw_addr)
				ADDR_DATA_BUFFER: begin
					// Same offset as the second address; select bit decides which one
					if (state.control[CTL_SECOND_SEL_BIT]) begin
						if (state.w_strb[0]) next_state.second_address = wbyte[7:1];
					end else if (!enabled) begin
						next_state.bresp = RESP_SLVERR;
					end else if (state.w_strb[0]) begin
						next_state.transmit_holding_buffer = wbyte;
						next_state.transmit_buffer_empty = 1'b0;
					end
				end
				ADDR_CONTROL: begin
					if (state.w_strb[0]) next_state.control = wbyte[4:0];
				end
				ADDR_STATUS: begin
					// Cont and match flags clear by a zero written after a read that saw one; a zero in the common bit clears common and cont at once
					if (state.w_strb[0] && !wbyte[ST_CONT_IRQ_BIT] && state.cont_read_one) begin
						next_state.continuous_transfer_irq_flag = 1'b0;
					end
					if (state.w_strb[0] && !wbyte[ST_SECOND_MATCH_BIT] && state.match_read_one) begin
						next_state.second_address_match_flag = 1'b0;
					end
					if (state.w_strb[0] && !wbyte[ST_COMMON_IRQ_BIT]) begin
						next_state.common_irq_flag = 1'b0;
						next_state.continuous_transfer_irq_flag = 1'b0;
					end
				end
				ADDR_IRQ_STATUS: begin
					if (state.w_strb[0]) begin
						next_state.irq_status = state.irq_status & ~wbyte[IRQ_W-1:0];
					end
				end
				ADDR_IRQ_MASK: begin
					if (state.w_strb[0]) next_state.irq_mask = wbyte[IRQ_W-1:0];
				end
				default: next_state.bresp = RESP_DECERR;
			endcase
		end

		// Software reads
		if (rd_fire) begin
			next_state.rvalid = 1'b1;
			next_state.rresp = RESP_OKAY;
			next_state.rdata = 32'h0000_0000;
			case (S_AXI_ARADDR)
				ADDR_DATA_BUFFER: begin
					if (state.control[CTL_SECOND_SEL_BIT]) begin
						next_state.rdata[7:0] = {state.second_address, 1'b0};
					end else if (!enabled) begin
						next_state.rresp = RESP_SLVERR;
					end else begin
						next_state.rdata[7:0] = state.receive_holding_buffer;
						next_state.receive_buffer_full = 1'b0;
					end
				end
				ADDR_CONTROL: next_state.rdata[4:0] = state.control;
				ADDR_STATUS: begin
					next_state.rdata[ST_TX_EMPTY_BIT] = state.transmit_buffer_empty;
					next_state.rdata[ST_RX_FULL_BIT] = state.receive_buffer_full;
					next_state.rdata[ST_COMMON_IRQ_BIT] = state.common_irq_flag;
					next_state.rdata[ST_SECOND_MATCH_BIT] = state.second_address_match_flag;
					next_state.rdata[ST_CONT_IRQ_BIT] = state.continuous_transfer_irq_flag;
					next_state.cont_read_one = state.continuous_transfer_irq_flag;
					next_state.match_read_one = state.second_address_match_flag;
				end
				ADDR_IRQ_STATUS: next_state.rdata[IRQ_W-1:0] = state.irq_status;
				ADDR_IRQ_MASK: next_state.rdata[IRQ_W-1:0] = state.irq_mask;
				ADDR_SECOND_ADDRESS: next_state.rdata[6:0] = state.second_address;
				default: next_state.rresp = RESP_DECERR;
			endcase
		end

		// Hardware sets win over software clears in the same cycle
		if (set_empty) next_state.transmit_buffer_empty = 1'b1;
		if (set_full) next_state.receive_buffer_full = 1'b1;
		if (set_cont) begin
			next_state.continuous_transfer_irq_flag = 1'b1;
			next_state.common_irq_flag = 1'b1;
			next_state.cont_read_one = 1'b0;
		end
		if (ev.start_seen) begin
			next_state.second_address_match_flag = 1'b0;
		end
		if (set_match) begin
			next_state.second_address_match_flag = 1'b1;
			next_state.match_read_one = 1'b0;
		end

		irq_events = '0;
		irq_events[IRQ_FRAME_BIT] = ev.frame_done;
		irq_events[IRQ_START_BIT] = ev.start_seen;
		irq_events[IRQ_CONT_BIT] = set_cont;
		next_state.irq_status = next_state.irq_status | irq_events;
		next_state.irq = |(state.irq_status & state.irq_mask);
		// Pin is released outside transmit mode; a low bit pulls the line low
		next_state.sda_out = !transmit_mode || ev.tx_bit;

		if (SRST) begin
			// Data buffers keep their content: they are undefined after reset
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.bvalid = 1'b0;
			next_state.bresp = RESP_OKAY;
			next_state.arready = 1'b0;
			next_state.rvalid = 1'b0;
			next_state.rdata = 32'h0000_0000;
			next_state.rresp = RESP_OKAY;
			next_state.control = CONTROL_RESET;
			next_state.second_address = SECOND_ADDRESS_RESET;
			next_state.transmit_buffer_empty = 1'b1;
			next_state.receive_buffer_full = 1'b0;
			next_state.common_irq_flag = 1'b0;
			next_state.continuous_transfer_irq_flag = 1'b0;
			next_state.cont_read_one = 1'b0;
			next_state.second_address_match_flag = 1'b0;
			next_state.match_read_one = 1'b0;
			next_state.first_frame = 1'b0;
			next_state.irq_status = '0;
			next_state.irq_mask = '0;
			next_state.irq = 1'b0;
			next_state.sda_out = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		state <= next_state;
	end

	assign S_AXI_AWREADY = !state.aw_held;
	assign S_AXI_WREADY = !state.w_held;
	assign S_AXI_BVALID = state.bvalid;
	assign S_AXI_BRESP = state.bresp;
	assign S_AXI_ARREADY = state.arready;
	assign S_AXI_RVALID = state.rvalid;
	assign S_AXI_RDATA = state.rdata;
	assign S_AXI_RRESP = state.rresp;
	assign IRQ = state.irq;
	assign SDA_OUT = 1'b0;
	assign SDA_OE_N = state.sda_out;
endmodule
`default_nettype wire

//--- hw/i2c_buf_pkg.sv
// Package: register map, field positions and reset values of the data buffer block
package i2c_buf_pkg;
	localparam int          DATA_W               = 8;
	localparam logic [7:0]  ADDR_DATA_BUFFER     = 8'h00;
	localparam logic [7:0]  ADDR_CONTROL         = 8'h04;
	localparam logic [7:0]  ADDR_STATUS          = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_STATUS      = 8'h0C;
	localparam logic [7:0]  ADDR_IRQ_MASK        = 8'h10;
	localparam logic [7:0]  ADDR_SECOND_ADDRESS  = 8'h14;
	localparam int          CTL_ENABLE_BIT       = 0;
	localparam int          CTL_LSB_FIRST_BIT    = 1;
	localparam int          CTL_SLAVE_BIT        = 2;
	localparam int          CTL_TRANSMIT_BIT     = 3;
	localparam int          CTL_SECOND_SEL_BIT   = 4;
	localparam int          ST_TX_EMPTY_BIT      = 0;
	localparam int          ST_RX_FULL_BIT       = 1;
	localparam int          ST_COMMON_IRQ_BIT    = 2;
	localparam int          ST_SECOND_MATCH_BIT  = 4;
	localparam int          ST_CONT_IRQ_BIT      = 5;
	localparam int          IRQ_FRAME_BIT        = 0;
	localparam int          IRQ_START_BIT        = 1;
	localparam int          IRQ_CONT_BIT         = 2;
	localparam int          IRQ_W                = 3;
	localparam logic [4:0]  CONTROL_RESET        = 5'h00;
	localparam logic [6:0]  SECOND_ADDRESS_RESET = 7'h00;
	localparam logic [1:0]  RESP_OKAY            = 2'h0;
	localparam logic [1:0]  RESP_SLVERR          = 2'h2;
	localparam logic [1:0]  RESP_DECERR          = 2'h3;
endpackage

//--- hw/link_event_if.sv
// Interface: bus events recovered from the link pins, passed to the buffer logic
`timescale 1ns/1ps
`default_nettype none
interface link_event_if;
	logic       frame_done;
	logic       start_seen;
	logic [7:0] frame_byte;
	logic [7:0] load_byte;
	logic       tx_bit;
	modport source (output frame_done, output start_seen, output frame_byte, input load_byte,
	                output tx_bit);
	modport sink   (input frame_done, input start_seen, input frame_byte, output load_byte,
	                input tx_bit);
endinterface
`default_nettype wire

//--- hw/pin_sync.sv
// Module: two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input  wire logic CLK,
	input  wire logic SRST,
	input  wire logic pin,
	output logic      level
);
	typedef struct packed {
		logic first;
		logic second;
	} sync_state_type;
	sync_state_type state;
	sync_state_type next_state;

	always_comb begin
		next_state.first = pin;
		next_state.second = state.first;
		if (SRST) begin
			next_state = '0;
		end
	end

	always_ff @(posedge CLK) begin
		state <= next_state;
	end

	assign level = state.second;
endmodule
`default_nettype wire

//--- hw/link_frame_tracker.sv
// Module: samples the link clock and data, finds start conditions and shifts frames
`timescale 1ns/1ps
`default_nettype none
module link_frame_tracker
	import i2c_buf_pkg::*;
(
	input  wire logic   CLK,
	input  wire logic   SRST,
	input  wire logic   scl_in,
	input  wire logic   sda_in,
	input  wire logic   lsb_first,
	link_event_if.source ev
);
	typedef struct packed {
		logic       scl_d;
		logic       sda_d;
		logic [3:0] count;
		logic [7:0] shifter;
		logic       done;
		logic       start;
		logic [7:0] frame;
		logic       tx_bit;
	} track_state_type;
	track_state_type state;
	track_state_type next_state;
	logic            scl_s;
	logic            sda_s;

	pin_sync u_scl (.CLK(CLK), .SRST(SRST), .pin(scl_in), .level(scl_s));
	pin_sync u_sda (.CLK(CLK), .SRST(SRST), .pin(sda_in), .level(sda_s));

	always_comb begin
		next_state = state;
		next_state.scl_d = scl_s;
		next_state.sda_d = sda_s;
		next_state.done = 1'b0;
		next_state.start = 1'b0;
		// Start: data falls while clock stays high
		if (scl_s && state.scl_d && state.sda_d && !sda_s) begin
			next_state.start = 1'b1;
			next_state.count = 4'h0;
			next_state.tx_bit = 1'b1;
		end else if (scl_s && !state.scl_d) begin
			if (state.count == 4'h8) begin
				// Ninth clock is the acknowledge; the frame closes here
				next_state.count = 4'h0;
				next_state.done = 1'b1;
				next_state.frame = state.shifter;
			end else begin
				next_state.count = state.count + 4'h1;
				next_state.shifter = lsb_first ? {sda_s, state.shifter[7:1]}
				                               : {state.shifter[6:0], sda_s};
			end
		end
		// Next bit goes out after the clock falls, so data never moves while it is high
		if (!scl_s && state.scl_d) begin
			if (state.count == 4'h8) begin
				next_state.tx_bit = 1'b1;
			end else if (lsb_first) begin
				next_state.tx_bit = ev.load_byte[state.count[2:0]];
			end else begin
				next_state.tx_bit = ev.load_byte[3'h7 - state.count[2:0]];
			end
		end
		if (SRST) begin
			next_state = '0;
			next_state.tx_bit = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		state <= next_state;
	end

	assign ev.frame_done = state.done;
	assign ev.start_seen = state.start;
	assign ev.frame_byte = state.frame;
	assign ev.tx_bit = state.tx_bit;
endmodule
`default_nettype wire

//--- dv/i2c_bus_master_model.sv
// Behavioural bus master that clocks frames into and out of the block
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master_model (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda_line
);
	// Both lines have pull-ups, so a released line idles high and the clock stands still
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Start or repeated start: data falls while the clock is high
	task automatic start_cond();
		sda_low = 1'b0;
		#50 scl = 1'b1;
		#100 sda_low = 1'b1;
		#100 scl = 1'b0;
		#50;
	endtask
	// Eight bits MSB first, then a released acknowledge slot; 200 ns per bit, long low phase
	// Long low phase leaves the block time to put its bit out; read at the end of high
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sda_low = ~tx[i];
			#150 scl = 1'b1;
			#50 rx[i] = sda_line;
			scl = 1'b0;
		end
		sda_low = 1'b0;
		#150 scl = 1'b1;
		#50 scl = 1'b0;
	endtask
	task automatic stop_cond();
		sda_low = 1'b1;
		#50 scl = 1'b1;
		#100 sda_low = 1'b0;
		#100;
	endtask
endmodule
`default_nettype wire

//--- dv/i2c_data_buffer_flags_checker.sv
// Bus handshake and reset checks on the data buffer block's ports
`timescale 1ns/1ps
`default_nettype none
module i2c_data_buffer_flags_checker
	import i2c_buf_pkg::*;
(
	input wire logic        CLK,
	input wire logic        SRST,
	input wire logic [7:0]  S_AXI_AWADDR,
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic [7:0]  S_AXI_ARADDR,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0]  S_AXI_RRESP,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic        SDA_OUT,
	input wire logic        SDA_OE_N,
	input wire logic        IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
	property p_rbyte; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000; endproperty
	a_rbyte: assert property (p_rbyte) else $error("read data wider than a byte");
	property p_rtake; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
	endproperty
	a_rtake: assert property (p_rtake) else $error("read answer late");
	property p_wtake;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID;
	endproperty
	a_wtake: assert property (p_wtake) else $error("write answer late");
	property p_unmapped;
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h14 |=> S_AXI_RRESP == RESP_DECERR;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	// The pin is open drain: only the enable may ever move
	property p_sdalow; SDA_OUT == 1'b0; endproperty
	a_sdalow: assert property (p_sdalow) else $error("data pin driven high");
	property p_reset; disable iff (1'b0)
		SRST |=> !S_AXI_BVALID && !S_AXI_RVALID && !S_AXI_ARREADY && !IRQ && SDA_OE_N;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not quiet in reset");
	c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
	c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
	c_irq: cover property ($rose(IRQ));
	c_drive: cover property (!SDA_OE_N);
endmodule
bind i2c_data_buffer_flags i2c_data_buffer_flags_checker chk (.CLK(CLK), .SRST(SRST),
	.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .IRQ(IRQ));
`default_nettype wire

//--- dv/i2c_data_buffer_flags_bench.sv
// Self-checking bench: register access, received and sent frames, flags and interrupt
`timescale 1ns/1ps
`default_nettype none
module i2c_data_buffer_flags_bench
	import i2c_buf_pkg::*;
();
	logic        CLK, SRST, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr, got;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic        awready, wready, bvalid, arready, rvalid, sda_out, sda_oe_n, irq, scl, sda_low;
	logic [1:0]  bresp, rresp, rsp;
	int          errors, check_count;
	wire         sda_line = ~sda_low & (sda_oe_n | sda_out);
	i2c_data_buffer_flags dut (.CLK(CLK), .SRST(SRST), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SCL_IN(scl),
		.SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .IRQ(irq));
	i2c_bus_master_model bus (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic hang();
		errors++;
		stop_test();
	endtask
	initial begin
		#1500000;
		hang();
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Each channel is released at the edge that takes it; no fixed latency is assumed
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge CLK);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge CLK);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
			n++;
			if (n > 300) hang();
		end
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge CLK);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge CLK);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
			n++;
			if (n > 300) hang();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_write(a, d, rsp);
		check("write response", 32'(RESP_OKAY), 32'(rsp));
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		axi_read(a, rd, rsp);
		check("read value", exp, rd & mask);
	endtask
	// Flags land a few cycles after the ninth clock rise; 20 cycles covers sync and lag
	task automatic frame(input logic st, input logic [7:0] b);
		if (st) bus.start_cond();
		bus.xfer(b, got);
		repeat (20) @(posedge CLK);
	endtask
	task automatic test_reset();
		rd_chk(ADDR_CONTROL, 32'hFFFFFFFF, 32'h00000000);
		rd_chk(ADDR_STATUS, 32'hFFFFFFFF, 32'h00000001);
		rd_chk(ADDR_IRQ_STATUS, 32'hFFFFFFFF, 32'h00000000);
		axi_read(8'h18, rd, rsp);
		check("unmapped response", 32'(RESP_DECERR), 32'(rsp));
		axi_read(ADDR_DATA_BUFFER, rd, rsp);
		check("disabled read response", 32'(RESP_SLVERR), 32'(rsp));
		axi_write(ADDR_DATA_BUFFER, 32'h00000055, rsp);
		check("disabled write response", 32'(RESP_SLVERR), 32'(rsp));
		check("irq idle", 32'h0, 32'(irq));
	endtask
	task automatic test_receive();
		wr(ADDR_CONTROL, 32'h00000001);
		frame(1'b1, 8'hA5);
		rd_chk(ADDR_STATUS, 32'h000000FF, 32'h00000027);
		frame(1'b0, 8'h3C);
		rd_chk(ADDR_DATA_BUFFER, 32'hFFFFFFFF, 32'h000000A5);
		rd_chk(ADDR_STATUS, 32'h000000FF, 32'h00000025);
		wr(ADDR_STATUS, 32'h00000000);
		rd_chk(ADDR_STATUS, 32'h000000FF, 32'h00000001);
		frame(1'b0, 8'h96);
		wr(ADDR_STATUS, 32'h00000020);
		rd_chk(ADDR_STATUS, 32'h000000FF, 32'h00000003);
		rd_chk(ADDR_DATA_BUFFER, 32'hFFFFFFFF, 32'h00000096);
		wr(ADDR_IRQ_MASK, 32'h00000001);
		repeat (3) @(posedge CLK);
		check("irq unmasked", 32'h1, 32'(irq));
		wr(ADDR_IRQ_MASK, 32'h00000000);
		repeat (3) @(posedge CLK);
		check("irq masked", 32'h0, 32'(irq));
		wr(ADDR_IRQ_MASK, 32'h00000001);
		wr(ADDR_IRQ_STATUS, 32'h00000007);
		repeat (3) @(posedge CLK);
		check("irq cleared", 32'h0, 32'(irq));
		rd_chk(ADDR_IRQ_STATUS, 32'hFFFFFFFF, 32'h00000000);
	endtask
	task automatic test_slave();
		wr(ADDR_CONTROL, 32'h00000011);
		wr(ADDR_DATA_BUFFER, 32'h000000B4);
		rd_chk(ADDR_SECOND_ADDRESS, 32'hFFFFFFFF, 32'h0000005A);
		wr(ADDR_CONTROL, 32'h00000005);
		frame(1'b1, 8'h00);
		rd_chk(ADDR_STATUS, 32'h00000030, 32'h00000000);
		axi_read(ADDR_DATA_BUFFER, rd, rsp);
		frame(1'b1, 8'hB4);
		rd_chk(ADDR_STATUS, 32'h00000030, 32'h00000030);
		frame(1'b1, 8'h80);
		rd_chk(ADDR_STATUS, 32'h00000010, 32'h00000000);
		axi_read(ADDR_DATA_BUFFER, rd, rsp);
	endtask
	task automatic test_transmit();
		wr(ADDR_CONTROL, 32'h00000009);
		axi_read(ADDR_STATUS, rd, rsp);
		wr(ADDR_STATUS, 32'h00000000);
		wr(ADDR_DATA_BUFFER, 32'h00000081);
		rd_chk(ADDR_STATUS, 32'h00000021, 32'h00000000);
		frame(1'b1, 8'hFF);
		rd_chk(ADDR_STATUS, 32'h00000021, 32'h00000021);
		bus.xfer(8'hFF, got);
		check("byte on the wire", 32'h00000081, 32'(got));
		bus.stop_cond();
	endtask
	initial begin
		errors = 0;
		check_count = 0;
		SRST = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h00000000;
		wstrb = 4'hF;
		repeat (8) @(posedge CLK);
		SRST <= 1'b0;
		@(posedge CLK);
		test_reset();
		test_receive();
		test_slave();
		test_transmit();
		stop_test();
	end
endmodule
`default_nettype wire
